// ===== design/dsram_pkg.sv
/*
 * Shared constants and carrier types for the double data rate split-port
 * SRAM cycle model: default geometry, synchroniser depth, strap settling
 * and the packed bundles for the sampled clock and control pins.
 * Assumes every user refers to these by dsram_pkg::name, with no import.
 */
package dsram_pkg;

    // ------------------------------------------------------------------
    // geometry and timing
    // ------------------------------------------------------------------
    localparam int unsigned DATA_W_DEF      = 18;  // word width of the default variant
    localparam int unsigned LANES_DEF       = 2;   // byte write select count
    localparam int unsigned ADDR_W_DEF      = 20;  // external burst address width
    localparam int unsigned SYNC_STAGES     = 2;   // flops on every pin input
    localparam int unsigned REF_PERIOD_NS   = 25;  // 40 MHz reference clock
    // straps are read once the pin synchroniser holds post-reset values
    localparam int unsigned SETTLE_CYCLES   = SYNC_STAGES + 1;
    localparam logic [1:0]  SETTLE_LAST     = 2'(SETTLE_CYCLES - 1);
    localparam logic        BURST_FIRST     = 1'b0;  // word A + 0
    localparam logic        BURST_SECOND    = 1'b1;  // word A + 1
    localparam int unsigned CTL_W           = 7;

    // ------------------------------------------------------------------
    // carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic k;          // positive input clock
        logic k_n;        // inverted input clock
        logic c;          // positive output clock
        logic c_n;        // inverted output clock
        logic rd_sel_n;   // read port select
        logic wr_sel_n;   // write port select
        logic pll_off;    // pll off strap level
    } dsram_ctl_t;

    localparam dsram_ctl_t CTL_PARK = 7'h7F;  // clocks parked high, deselected

    typedef struct packed {
        logic k;
        logic k_n;
        logic c;
        logic c_n;
    } dsram_edge_t;

    typedef enum logic [0:0] {
        DSRAM_SETTLE,
        DSRAM_RUN
    } dsram_phase_t;

endpackage : dsram_pkg

// ===== design/dsram_sync.sv
/*
 * Two-flop synchroniser for a bundle of asynchronous pin inputs.
 * Assumes the bundle's bits are independent levels; multi-bit words are
 * only read at an input clock edge, long after they have settled.
 */
`timescale 1ns/1ps
`default_nettype none

module dsram_sync #(
    parameter int unsigned       WIDTH   = 1,
    parameter logic [WIDTH-1:0]  RST_VAL = '0
) (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             reset,
    input  wire logic             ce,
    // pins in, synchronised out
    input  wire logic [WIDTH-1:0] d_in,
    output logic      [WIDTH-1:0] d_out
);

    typedef struct packed {
        logic [WIDTH-1:0] meta_r;
        logic [WIDTH-1:0] sync_r;
    } dsram_sync_st_t;

    dsram_sync_st_t st_r;
    dsram_sync_st_t st_nxt;

    // meta stage feeds only the second stage
    always_comb
    begin
        st_nxt = st_r;
        if (ce)
        begin
            st_nxt.meta_r = d_in;
            st_nxt.sync_r = st_r.meta_r;
        end
    end

    // register the state
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            st_r <= {RST_VAL, RST_VAL};
        else
            st_r <= st_nxt;
    end

    assign d_out = st_r.sync_r;

endmodule : dsram_sync

`default_nettype wire

// ===== design/dsram_mem.sv
/*
 * Storage array with a lane-masked write port and a read port whose data
 * come out of a register one cycle after the request.
 * Assumes at most one write and one read per cycle; a read of the word
 * being written in the same cycle returns the old contents.
 */
`timescale 1ns/1ps
`default_nettype none

module dsram_mem #(
    parameter int unsigned ADDR_W = dsram_pkg::ADDR_W_DEF + 1,
    parameter int unsigned DATA_W = dsram_pkg::DATA_W_DEF,
    parameter int unsigned LANES  = dsram_pkg::LANES_DEF
) (
    // clock
    input  wire logic              ref_clk,
    input  wire logic              ce,
    // write port
    input  wire logic              wr_en,
    input  wire logic [LANES-1:0]  wr_lane,
    input  wire logic [ADDR_W-1:0] wr_addr,
    input  wire logic [DATA_W-1:0] wr_data,
    // read port
    input  wire logic              rd_en,
    input  wire logic [ADDR_W-1:0] rd_addr,
    output logic      [DATA_W-1:0] rd_data
);

    localparam int unsigned LANE_W = DATA_W / LANES;

    logic [DATA_W-1:0] mem [0:(2**ADDR_W)-1];
    logic [DATA_W-1:0] rd_data_r;

    // lanes with a clear enable keep their stored bits
    always_ff @(posedge ref_clk)
    begin
        if (ce)
        begin
            if (rd_en)
                rd_data_r <= mem[rd_addr];
            if (wr_en)
            begin
                for (int i = 0; i < LANES; i++)
                begin
                    if (wr_lane[i])
                        mem[wr_addr][i*LANE_W +: LANE_W] <= wr_data[i*LANE_W +: LANE_W];
                end
            end
        end
    end

    assign rd_data = rd_data_r;

endmodule : dsram_mem

`default_nettype wire

// ===== design/dsram_top.sv
/*
 * Cycle behaviour of a split-port double data rate SRAM: two-word burst
 * writes with per-beat lane masks, two-word burst reads with 1.5 or 1
 * cycle latency, no-operation and stopped-clock standby.
 * Assumes the memory clocks are pins much slower than ref_clk (at least
 * four ref_clk cycles per half period), so every pin edge is seen after
 * the synchroniser and pin data have settled by then.
 */
// Notes on behaviour
// - a write starts when the write select is low at a positive input clock rise, taking address and word one there and word two at the next inverted clock rise.
// - a read started at cycle t gives word one at the inverted output clock rise of t + 1 and word two at the output clock rise of t + 2.
// - every access moves two words, from A + 0 then A + 1, with A the address taken at the start.
// - write data are taken on rises of both input clocks, one word per edge.
// - read data are launched on output clock rises, or on input clock rises in single clock mode.
// - with two lanes, select 0 low stores the lower lane and select 1 low the upper lane, while a lane whose select is high keeps its bits.
// - with every lane select high on a beat the addressed word is left untouched.
// - with one lane, the single select low stores the whole word and high stores nothing.
// - lane selects are sampled afresh on each beat, so the two beats of one write may carry different masks.
// - after power-up both ports are deselected and the read outputs are off until a read is issued.
// - with the pll off strap low the read latency is one cycle instead of one and a half.
`timescale 1ns/1ps
`default_nettype none

module dsram_top #(
    parameter int unsigned DATA_W = dsram_pkg::DATA_W_DEF,
    parameter int unsigned LANES  = dsram_pkg::LANES_DEF,
    parameter int unsigned ADDR_W = dsram_pkg::ADDR_W_DEF
) (
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              reset,
    input  wire logic              ce,
    // memory clock pins
    input  wire logic              k_clk,
    input  wire logic              k_clk_n,
    input  wire logic              out_clk,
    input  wire logic              out_clk_n,
    // control and write data pins
    input  wire logic              read_port_sel_n,
    input  wire logic              write_port_sel_n,
    input  wire logic [LANES-1:0]  byte_write_sel_n,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wr_data,
    // strap
    input  wire logic              pll_off_strap,
    // read data pins
    output logic      [DATA_W-1:0] rd_data,
    output logic                   rd_data_oe
);

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    localparam int unsigned PIN_W = dsram_pkg::CTL_W + LANES + ADDR_W + DATA_W;

    dsram_pkg::dsram_ctl_t ctl_in;
    dsram_pkg::dsram_ctl_t s_ctl;
    logic [LANES-1:0]      s_lane_n;
    logic [ADDR_W-1:0]     s_addr;
    logic [DATA_W-1:0]     s_data;

    assign ctl_in = '{k: k_clk, k_n: k_clk_n, c: out_clk, c_n: out_clk_n,
                      rd_sel_n: read_port_sel_n, wr_sel_n: write_port_sel_n, pll_off: pll_off_strap};

    // parked-high reset value keeps a false edge or select out of the first cycles
    dsram_sync #(
        .WIDTH   (PIN_W),
        .RST_VAL ({PIN_W{1'b1}})
    ) u_sync (
        .ref_clk (ref_clk),
        .reset   (reset),
        .ce      (ce),
        .d_in    ({ctl_in, byte_write_sel_n, addr, wr_data}),
        .d_out   ({s_ctl, s_lane_n, s_addr, s_data})
    );

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        dsram_pkg::dsram_phase_t phase;
        logic [1:0]              settle_cnt;
        logic                    single_clk;   // strap: output timing from input clocks
        logic                    half_lat;     // strap: 1.5 cycle latency
        dsram_pkg::dsram_edge_t  prev;
        logic                    rd0_v;        // read taken, waiting for next k rise
        logic [ADDR_W-1:0]       rd0_a;
        logic                    rd1_v;        // read due for its first word
        logic [ADDR_W-1:0]       rd1_a;
        logic                    rd2_v;        // read due for its second word
        logic [ADDR_W-1:0]       rd2_a;
        logic                    wr_pend;      // second write beat due
        logic [ADDR_W-1:0]       wr_a;
        logic                    q_load;       // array data arrive this cycle
        logic [DATA_W-1:0]       q;
        logic                    q_oe;
    } dsram_top_st_t;

    dsram_top_st_t st_r;
    dsram_top_st_t st_nxt;

    // array port signals
    logic              mem_wr_en;
    logic [LANES-1:0]  mem_wr_lane;
    logic [ADDR_W:0]   mem_wr_addr;
    logic              mem_rd_en;
    logic [ADDR_W:0]   mem_rd_addr;
    logic [DATA_W-1:0] mem_rd_data;

    // edge events, only meaningful once running
    logic run;
    logic k_rise;
    logic kn_rise;
    logic o_pos;
    logic o_neg;
    logic first_evt;
    logic second_evt;
    logic out_busy;

    assign run        = (st_r.phase == dsram_pkg::DSRAM_RUN);
    assign k_rise     = run && s_ctl.k && !st_r.prev.k;
    assign kn_rise    = run && s_ctl.k_n && !st_r.prev.k_n;
    assign o_pos      = run && (st_r.single_clk ? k_rise : (s_ctl.c && !st_r.prev.c));
    assign o_neg      = run && (st_r.single_clk ? kn_rise : (s_ctl.c_n && !st_r.prev.c_n));
    assign first_evt  = st_r.half_lat ? o_neg : o_pos;
    assign second_evt = st_r.half_lat ? o_pos : o_neg;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    // events are handled in clock order: a second word due, k rise, first word, k_n rise
    always_comb
    begin
        st_nxt      = st_r;
        out_busy    = 1'b0;
        mem_wr_en   = 1'b0;
        mem_wr_lane = '0;
        mem_wr_addr = '0;
        mem_rd_en   = 1'b0;
        mem_rd_addr = '0;
        st_nxt.prev = '{k: s_ctl.k, k_n: s_ctl.k_n, c: s_ctl.c, c_n: s_ctl.c_n};
        st_nxt.q_load = 1'b0;

        // straps are caught once, after the synchroniser has settled
        if (!run)
        begin
            st_nxt.settle_cnt = st_r.settle_cnt + 2'h1;
            if (st_r.settle_cnt == dsram_pkg::SETTLE_LAST)
            begin
                st_nxt.phase      = dsram_pkg::DSRAM_RUN;
                st_nxt.single_clk = s_ctl.c && s_ctl.c_n;
                st_nxt.half_lat   = s_ctl.pll_off;
            end
        end

        // second word of a burst from A + 1
        if (second_evt && st_r.rd2_v)
        begin
            mem_rd_en     = 1'b1;
            mem_rd_addr   = {st_r.rd2_a, dsram_pkg::BURST_SECOND};
            st_nxt.rd2_v  = 1'b0;
            st_nxt.q_load = 1'b1;
            out_busy      = 1'b1;
        end

        // positive input clock: advance reads, take new accesses
        if (k_rise)
        begin
            st_nxt.rd1_v = st_r.rd0_v;
            st_nxt.rd1_a = st_r.rd0_a;
            st_nxt.rd0_v = !s_ctl.rd_sel_n;
            st_nxt.rd0_a = s_addr;
            if (!s_ctl.wr_sel_n)
            begin
                // first beat shares the edge with the address
                mem_wr_en      = |(~s_lane_n);
                mem_wr_lane    = ~s_lane_n;
                mem_wr_addr    = {s_addr, dsram_pkg::BURST_FIRST};
                st_nxt.wr_pend = 1'b1;
                st_nxt.wr_a    = s_addr;
            end
        end

        // first word of a burst from A + 0
        if (first_evt && st_nxt.rd1_v)
        begin
            mem_rd_en     = 1'b1;
            mem_rd_addr   = {st_nxt.rd1_a, dsram_pkg::BURST_FIRST};
            st_nxt.rd1_v  = 1'b0;
            st_nxt.rd2_v  = 1'b1;
            st_nxt.rd2_a  = st_nxt.rd1_a;
            st_nxt.q_load = 1'b1;
            out_busy      = 1'b1;
        end

        // inverted input clock: second write beat with its own mask
        if (kn_rise && st_r.wr_pend)
        begin
            mem_wr_en      = |(~s_lane_n);
            mem_wr_lane    = ~s_lane_n;
            mem_wr_addr    = {st_r.wr_a, dsram_pkg::BURST_SECOND};
            st_nxt.wr_pend = 1'b0;
        end

        // an output edge with nothing to send lets the pins float
        if ((o_pos || o_neg) && !out_busy)
            st_nxt.q_oe = 1'b0;

        // array data reach the pins two cycles after the request
        if (st_r.q_load)
        begin
            st_nxt.q    = mem_rd_data;
            st_nxt.q_oe = 1'b1;
        end

        // a low enable freezes everything, array ports included
        if (!ce)
        begin
            st_nxt    = st_r;
            mem_wr_en = 1'b0;
            mem_rd_en = 1'b0;
        end
    end

    // power-up state: deselected, outputs off, clocks seen as parked high
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            st_r      <= '0;
            st_r.prev <= 4'hF;
        end
        else
            st_r <= st_nxt;
    end

    assign rd_data    = st_r.q;
    assign rd_data_oe = st_r.q_oe;

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    dsram_mem #(
        .ADDR_W  (ADDR_W + 1),
        .DATA_W  (DATA_W),
        .LANES   (LANES)
    ) u_mem (
        .ref_clk (ref_clk),
        .ce      (ce),
        .wr_en   (mem_wr_en),
        .wr_lane (mem_wr_lane),
        .wr_addr (mem_wr_addr),
        .wr_data (s_data),
        .rd_en   (mem_rd_en),
        .rd_addr (mem_rd_addr),
        .rd_data (mem_rd_data)
    );

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset || !ce);

    sequence wr_start_s;
        k_rise && !s_ctl.wr_sel_n;
    endsequence

    sequence rd_start_s;
        k_rise && !s_ctl.rd_sel_n;
    endsequence

    // outputs only turn on after a load from the array
    oe_after_load_a: assert property ($rose(st_r.q_oe) |-> $past(st_r.q_load))
        else $error("read outputs enabled without a read");

    read_take_a: assert property (rd_start_s |=> st_r.rd0_v && st_r.rd0_a == $past(s_addr))
        else $error("read address not taken at k rise");

    // a no-operation edge writes nothing there and leaves no read queued after it
    nop_idle_a: assert property (k_rise && s_ctl.rd_sel_n && s_ctl.wr_sel_n
                                 |-> !mem_wr_en ##1 !st_r.rd0_v)
        else $error("no-operation cycle started an access");

    burst_pair_a: assert property (mem_rd_en && mem_rd_addr[0] == dsram_pkg::BURST_SECOND
                                   |-> $past(st_r.rd2_v) && mem_rd_addr[ADDR_W:1] == st_r.rd2_a)
        else $error("second read word not from A + 1");

    first_then_second_a: assert property (mem_rd_en && mem_rd_addr[0] == dsram_pkg::BURST_FIRST
                                          |=> st_r.rd2_v && st_r.rd2_a == $past(mem_rd_addr[ADDR_W:1]))
        else $error("first read word left no second word due");

    write_first_a: assert property (wr_start_s ##0 !(&s_lane_n)
                                    |-> mem_wr_en
                                        && mem_wr_addr == {s_addr, dsram_pkg::BURST_FIRST}
                                        ##1 st_r.wr_pend)
        else $error("first write beat not stored at A + 0");

    write_second_a: assert property (kn_rise && st_r.wr_pend && !(&s_lane_n)
                                     |-> mem_wr_en && mem_wr_addr == {st_r.wr_a, dsram_pkg::BURST_SECOND})
        else $error("second write beat not stored at A + 1");

    lane_mask_a: assert property (mem_wr_en |-> mem_wr_lane == ~s_lane_n)
        else $error("write lanes differ from sampled selects");

    masked_beat_a: assert property ((k_rise || kn_rise) && (&s_lane_n) |-> !mem_wr_en)
        else $error("array written with all lanes deselected");

    load_to_pins_a: assert property (st_r.q_load |=> st_r.q_oe && st_r.q == $past(mem_rd_data))
        else $error("array data did not reach the read pins");

    latency_edge_a: assert property (mem_rd_en && mem_rd_addr[0] == dsram_pkg::BURST_FIRST
                                     |-> (st_r.half_lat ? o_neg : o_pos))
        else $error("first read word on the wrong output edge");

endmodule : dsram_top

`default_nettype wire

// ===== verif/dsram_ctl_model.sv
/*
 * Memory controller clock model: the input clock pair and the output
 * clock pair, sixteen ref_clk cycles to one memory clock cycle.
 * Assumes the bench drives selects, address and data against phase.
 */
`timescale 1ns/1ps
`default_nettype none

module dsram_ctl_model (
    // bench clock
    input  wire logic  ref_clk,
    // mode controls
    input  wire logic  run,
    input  wire logic  sc_strap,
    // memory clock pins and position in the cycle
    output logic       k_clk,
    output logic       k_clk_n,
    output logic       out_clk,
    output logic       out_clk_n,
    output logic [3:0] phase
);
    // ------------------------------------------------------------
    // clock generation
    // ------------------------------------------------------------
    logic       stop;
    logic [3:0] nxt;

    initial
    begin
        phase     = 4'h0;
        k_clk     = 1'b1;
        k_clk_n   = 1'b0;
        out_clk   = 1'b1;
        out_clk_n = 1'b0;
    end

    // freezes only with k high, so parking never makes a k rise
    always @(posedge ref_clk)
    begin
        #1;
        stop      = !run && phase == 4'h4;
        nxt       = stop ? phase : phase + 4'h1;
        phase     = nxt;
        k_clk     = !nxt[3] || stop;
        k_clk_n   = nxt[3] || stop;
        out_clk   = sc_strap || k_clk;
        out_clk_n = sc_strap || k_clk_n;
    end
endmodule : dsram_ctl_model

`default_nettype wire

// ===== verif/testbench.sv
/*
 * Self-checking bench: random and corner bursts under three strap
 * settings, a shadow memory scoreboard, and a stopped-clock standby.
 * Assumes the design package, design files and clock model come first.
 */
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; $display("[ERR] %s exp %h got %h", nm, e, g); end end

module testbench;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam int AW = 4;
    typedef struct { int due; logic [AW:0] wa; } dsram_exp_t;

    logic          ref_clk          = 1'b0;
    logic          reset            = 1'b1;
    logic          run              = 1'b1;
    logic          sc               = 1'b0;
    logic          read_port_sel_n  = 1'b1;
    logic          write_port_sel_n = 1'b1;
    logic [1:0]    byte_write_sel_n = 2'h3;
    logic [AW-1:0] addr             = 4'h0;
    logic [17:0]   wr_data          = 18'h0;
    logic          pll_off_strap    = 1'b1;
    logic          k_clk, k_clk_n, out_clk, out_clk_n, rd_data_oe, last_r;
    logic [3:0]    phase;
    logic [AW-1:0] last_a;
    logic [17:0]   rd_data, hold;
    logic [31:0]   rnd;
    logic [17:0]   mem [32];
    logic [8:0]    mem9 [32];
    logic [8:0]    rd9;
    logic          oe9;
    dsram_exp_t    q [$];
    int            tick = 0, last_rd = -1000, lat = 8, compares = 0, fail_count = 0, seed = 49119;

    always #12.5 ref_clk = ~ref_clk;

    always @(posedge ref_clk)
        tick <= tick + 1;

    dsram_ctl_model ctl (.ref_clk(ref_clk), .run(run), .sc_strap(sc), .k_clk(k_clk), .k_clk_n(k_clk_n),
                         .out_clk(out_clk), .out_clk_n(out_clk_n), .phase(phase));

    dsram_top #(.DATA_W(18), .LANES(2), .ADDR_W(AW)) dut (
        .ref_clk(ref_clk), .reset(reset), .ce(1'b1), .k_clk(k_clk), .k_clk_n(k_clk_n),
        .out_clk(out_clk), .out_clk_n(out_clk_n), .read_port_sel_n(read_port_sel_n),
        .write_port_sel_n(write_port_sel_n), .byte_write_sel_n(byte_write_sel_n), .addr(addr),
        .wr_data(wr_data), .pll_off_strap(pll_off_strap), .rd_data(rd_data), .rd_data_oe(rd_data_oe));

    // one-lane variant on the same pins, its single select is lane select 0
    dsram_top #(.DATA_W(9), .LANES(1), .ADDR_W(AW)) dut9 (
        .ref_clk(ref_clk), .reset(reset), .ce(1'b1), .k_clk(k_clk), .k_clk_n(k_clk_n),
        .out_clk(out_clk), .out_clk_n(out_clk_n), .read_port_sel_n(read_port_sel_n),
        .write_port_sel_n(write_port_sel_n), .byte_write_sel_n(byte_write_sel_n[0]), .addr(addr),
        .wr_data(wr_data[8:0]), .pll_off_strap(pll_off_strap), .rd_data(rd9), .rd_data_oe(oe9));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic end_sim;
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_sim

    // bounded wait for a clock model phase, then step off the edge
    task automatic wait_ph(input logic [3:0] n);
        int i;
        for (i = 0; i < 200; i++)
        begin
            @(posedge ref_clk);
            if (phase === n)
                break;
        end
        #1;
        if (i == 200)
        begin
            fail_count++;
            end_sim();
        end
    endtask : wait_ph

    // shadow store of one beat, lane by lane
    function automatic void put(logic [AW:0] i, logic [17:0] d, logic [1:0] m);
        if (!m[0])
            mem[i][8:0] = d[8:0];
        if (!m[1])
            mem[i][17:9] = d[17:9];
        if (!m[0])
            mem9[i] = d[8:0];
    endfunction : put

    // one memory cycle: beat one set 4 before k rise, beat two 4 before k_n rise
    task automatic slot(input logic r_n, input logic w_n, input logic [AW-1:0] a, input logic [17:0] d0,
                        input logic [17:0] d1, input logic [1:0] m0, input logic [1:0] m1);
        // a write to the word read one cycle earlier would race its output edge
        if (!w_n && last_r && a == last_a)
            a = a ^ 4'h1;
        wait_ph(4'hC);
        read_port_sel_n  = r_n;
        write_port_sel_n = w_n;
        addr             = a;
        wr_data          = d0;
        byte_write_sel_n = m0;
        wait_ph(4'h0);
        if (!w_n)
            put({a, 1'b0}, d0, m0);
        if (!r_n)
        begin
            q.push_back('{tick + 21 + lat, {a, 1'b0}});
            q.push_back('{tick + 29 + lat, {a, 1'b1}});
            last_rd = tick;
        end
        last_r           = !r_n;
        last_a           = a;
        wait_ph(4'h4);
        read_port_sel_n  = 1'b1;
        write_port_sel_n = 1'b1;
        addr             = 4'($random(seed));
        wr_data          = d1;
        byte_write_sel_n = m1;
        wait_ph(4'h8);
        if (!w_n)
            put({a, 1'b1}, d1, m1);
    endtask : slot

    // ------------------------------------------------------------
    // scoreboard, sampled mid-cycle
    // ------------------------------------------------------------
    always @(negedge ref_clk)
    begin
        if (q.size() > 0 && q[0].due == tick)
        begin
            `CHK("rd_data_oe", 1'b1, rd_data_oe)
            `CHK("rd_data", mem[q[0].wa], rd_data)
            `CHK("rd9", {1'b1, mem9[q[0].wa]}, {oe9, rd9})
            void'(q.pop_front());
        end
        if (tick == last_rd + 41 + lat)
            `CHK("oe_idle", 2'h0, {rd_data_oe, oe9})
    end

    // ------------------------------------------------------------
    // main sequence: normal, pll off, single clock
    // ------------------------------------------------------------
    initial
    begin
        for (int c = 0; c < 3; c++)
        begin
            reset         = 1'b1;
            sc            = (c == 2);
            pll_off_strap = (c != 1);
            lat           = (c == 1) ? 0 : 8;
            last_r        = 1'b0;
            last_rd       = -1000;
            q.delete();
            repeat (12) @(posedge ref_clk);
            #1;
            `CHK("oe_reset", 1'b0, rd_data_oe)
            reset = 1'b0;
            for (int i = 0; i < 16; i++)
                slot(1'b1, 1'b0, 4'(i), 18'($random(seed)), 18'($random(seed)), 2'h0, 2'h0);
            `CHK("oe_no_read", 1'b0, rd_data_oe)
            // every mask pair, read in the same cycle as the write
            for (int i = 0; i < 16; i++)
                slot(1'b0, 1'b0, 4'(i), 18'($random(seed)), 18'($random(seed)), 2'(i), 2'(i >> 2));
            for (int i = 0; i < 64; i++)
            begin
                rnd = $random(seed);
                slot(rnd[0] || i > 59, rnd[1] || i > 59, rnd[5:2], 18'($random(seed)),
                     18'($random(seed)), rnd[7:6], rnd[9:8]);
            end
            hold = rd_data;
            run  = 1'b0;
            repeat (60) @(posedge ref_clk);
            #1;
            `CHK("standby_oe", 1'b0, rd_data_oe)
            `CHK("standby_data", hold, rd_data)
            // a word whose due cycle slipped by would otherwise never be checked
            `CHK("reads_left", 0, q.size())
            run = 1'b1;
        end
        end_sim();
    end
endmodule : testbench

`default_nettype wire
